// ---- fhlu_pkg.sv ----
// shared constants and types for the float-single and halfword load unit
package fhlu_pkg;

    // field positions (bit 0 of the architecture is the word's msb)
    localparam int PRI_MSB    = 31;  // bits 0-5
    localparam int PRI_LSB    = 26;
    localparam int TGT_MSB    = 25;  // bits 6-10
    localparam int TGT_LSB    = 21;
    localparam int BASE_MSB   = 20;  // bits 11-15
    localparam int BASE_LSB   = 16;
    localparam int INDEX_MSB  = 15;  // bits 16-20
    localparam int INDEX_LSB  = 11;
    localparam int XO_MSB     = 10;  // bits 21-30
    localparam int XO_LSB     = 1;
    localparam int DISP_MSB   = 15;  // bits 16-31
    localparam int DISP_LSB   = 0;
    localparam int HALF_SIGN  = 15;  // halfword bit 0

    // opcodes
    localparam logic [5:0] PRI_INDEXED      = 6'h1f;  // 31
    localparam logic [5:0] PRI_HALF_ALG     = 6'h2a;  // 42
    localparam logic [5:0] PRI_HALF_ALG_UPD = 6'h2b;  // 43
    localparam logic [9:0] XO_FLT_UPD       = 10'h237; // 567
    localparam logic [9:0] XO_FLT           = 10'h217; // 535
    localparam logic [9:0] XO_HALF_UPD      = 10'h177; // 375

    // single to double exponent handling
    localparam logic [10:0] EXP_REBIAS  = 11'h380;  // 1023 - 127
    localparam logic [10:0] EXP_DENORM  = 11'h36a;  // 1023 - 149
    localparam logic [10:0] EXP_ALL_ONE = 11'h7ff;
    localparam logic [4:0]  REG_ZERO    = 5'h00;

    // one-hot sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ADDR = 3'b010,
        ST_MEM  = 3'b100
    } fhlu_state_e;

    // decoded instruction held while it executes
    typedef struct packed {
        logic        is_float;  // float load, else halfword algebraic
        logic        indexed;   // index register, else displacement
        logic        update;    // base update form
        logic [4:0]  tgt;
        logic [4:0]  base;
        logic [4:0]  index;
        logic [15:0] disp;
    } fhlu_dec_s;

endpackage

// ---- fhlu_sp2dp.sv ----
// single-precision to double-precision widening, exact for every input
`timescale 1ns/10ps
`default_nettype none
module fhlu_sp2dp (
    // single-precision word in
    input  wire logic [31:0] single_i,
    // double-precision word out
    output logic      [63:0] double_o
);
    logic        sign;
    logic [7:0]  exp_s;
    logic [22:0] frac_s;
    logic [4:0]  lead;
    logic [52:0] norm;

    assign sign   = single_i[31];
    assign exp_s  = single_i[30:23];
    assign frac_s = single_i[22:0];

    // find the leading one of a denormal fraction; highest set bit wins
    always_comb begin
        lead = 5'h00;
        for (int i = 0; i < 23; i++) begin
            if (frac_s[i]) begin
                lead = 5'(i);
            end
        end
        norm = {30'h0, frac_s} << (6'd52 - {1'b0, lead});
    end

    // denormals become normals in double range, so nothing is rounded
    always_comb begin
        if (exp_s == 8'hff) begin
            double_o = {sign, fhlu_pkg::EXP_ALL_ONE, frac_s, 29'h0};
        end else if (exp_s != 8'h00) begin
            double_o = {sign, fhlu_pkg::EXP_REBIAS + {3'h0, exp_s}, frac_s, 29'h0};
        end else if (frac_s == 23'h0) begin
            double_o = {sign, 63'h0};
        end else begin
            double_o = {sign, fhlu_pkg::EXP_DENORM + {6'h0, lead}, norm[51:0]};
        end
    end
endmodule
`default_nettype wire

// ---- fhlu_load_unit.sv ----
// decoder and sequencer for float-single and algebraic halfword loads
// Operation
// - opcode 31, extended 567: indexed float-single load with base update.
// - opcode 31, extended 535: indexed float-single load without update.
// - opcode 42: displacement sign-extending halfword load without update.
// - opcode 43: displacement sign-extending halfword load, conditional base update.
// - opcode 31, extended 375: indexed sign-extending halfword load with update.
// - displacement sign-extended to 32 bits; base field zero means displacement alone.
// - indexed address is base plus index; base field zero means index alone.
// - target bits 6-10, base bits 11-15, index bits 16-20.
// - float loads widen the fetched single word to double, write float register.
// - float update writes address to base if base nonzero and no exception.
// - halfword update needs base nonzero, base unlike target, and no exception.
// - halfword goes in bits 16-31, bits 0-15 copy halfword bit 0.
// - float loads never touch the float status and control register.
// - halfword loads never touch fixed-point exception register nor condition field 0.
`timescale 1ns/10ps
`default_nettype none
module fhlu_load_unit (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // issue stage
    input  wire logic        instr_valid_i,
    input  wire logic [31:0] instr_i,
    output logic             instr_ready_o,
    output logic             illegal_o,
    output logic             done_o,
    // integer register file read ports, data returns in the same cycle
    output logic [4:0]       base_raddr_o,
    output logic [4:0]       index_raddr_o,
    input  wire logic [31:0] base_rdata_i,
    input  wire logic [31:0] index_rdata_i,
    // storage access path
    output logic             mem_req_o,
    output logic [31:0]      mem_addr_o,
    output logic             mem_half_o,
    input  wire logic        mem_ack_i,
    input  wire logic [31:0] mem_rdata_i,
    input  wire logic        mem_align_err_i,
    input  wire logic        mem_dstor_err_i,
    // exceptions reported to the issue stage
    output logic             exc_align_o,
    output logic             exc_dstor_o,
    // register file write ports
    output logic             fpr_we_o,
    output logic [4:0]       fpr_waddr_o,
    output logic [63:0]      fpr_wdata_o,
    output logic             gpr_we_o,
    output logic [4:0]       gpr_waddr_o,
    output logic [31:0]      gpr_wdata_o,
    output logic             upd_we_o,
    output logic [4:0]       upd_waddr_o,
    output logic [31:0]      upd_wdata_o
);
    fhlu_pkg::fhlu_state_e state_r;
    fhlu_pkg::fhlu_dec_s   dec_r;
    fhlu_pkg::fhlu_dec_s   dec_nxt;
    logic                  hit;
    logic [5:0]            pri;
    logic [9:0]            xo;
    logic [31:0]           ea_nxt;
    logic [31:0]           ea_r;
    logic [63:0]           widened;
    logic                  take;
    logic                  finish;
    logic                  any_err;

    // field extraction with architecture bit 0 at the word's msb
    assign pri = instr_i[fhlu_pkg::PRI_MSB:fhlu_pkg::PRI_LSB];
    assign xo  = instr_i[fhlu_pkg::XO_MSB:fhlu_pkg::XO_LSB];

    // opcode decode; anything else is refused as illegal
    always_comb begin
        dec_nxt = '0;
        hit     = 1'b1;
        dec_nxt.tgt   = instr_i[fhlu_pkg::TGT_MSB:fhlu_pkg::TGT_LSB];
        dec_nxt.base  = instr_i[fhlu_pkg::BASE_MSB:fhlu_pkg::BASE_LSB];
        dec_nxt.index = instr_i[fhlu_pkg::INDEX_MSB:fhlu_pkg::INDEX_LSB];
        dec_nxt.disp  = instr_i[fhlu_pkg::DISP_MSB:fhlu_pkg::DISP_LSB];
        if (pri == fhlu_pkg::PRI_HALF_ALG) begin
            dec_nxt.indexed = 1'b0;
        end else if (pri == fhlu_pkg::PRI_HALF_ALG_UPD) begin
            dec_nxt.update  = 1'b1;
        end else if (pri == fhlu_pkg::PRI_INDEXED && xo == fhlu_pkg::XO_FLT_UPD) begin
            dec_nxt.is_float = 1'b1;
            dec_nxt.indexed  = 1'b1;
            dec_nxt.update   = 1'b1;
        end else if (pri == fhlu_pkg::PRI_INDEXED && xo == fhlu_pkg::XO_FLT) begin
            dec_nxt.is_float = 1'b1;
            dec_nxt.indexed  = 1'b1;
        end else if (pri == fhlu_pkg::PRI_INDEXED && xo == fhlu_pkg::XO_HALF_UPD) begin
            dec_nxt.indexed  = 1'b1;
            dec_nxt.update   = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    // effective address; a zero base field means no base term at all
    always_comb begin
        logic [31:0] base_term;
        logic [31:0] off_term;
        base_term = (dec_r.base == fhlu_pkg::REG_ZERO) ? 32'h0 : base_rdata_i;
        off_term  = dec_r.indexed ? index_rdata_i
                                  : {{16{dec_r.disp[15]}}, dec_r.disp};
        ea_nxt    = base_term + off_term;
    end

    assign take    = instr_valid_i && instr_ready_o && state_r == fhlu_pkg::ST_IDLE;
    assign finish  = state_r == fhlu_pkg::ST_MEM && mem_ack_i;
    assign any_err = mem_align_err_i || mem_dstor_err_i;

    fhlu_sp2dp u_widen (
        .single_i (mem_rdata_i),
        .double_o (widened)
    );

    // sequencer: one instruction in flight, ready only while idle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r       <= fhlu_pkg::ST_IDLE;
            instr_ready_o <= 1'b1;
            illegal_o     <= 1'b0;
        end else begin
            illegal_o <= take && !hit;
            case (state_r)
                fhlu_pkg::ST_IDLE: begin
                    if (take && hit) begin
                        state_r       <= fhlu_pkg::ST_ADDR;
                        instr_ready_o <= 1'b0;
                    end
                end
                fhlu_pkg::ST_ADDR: begin
                    state_r <= fhlu_pkg::ST_MEM;
                end
                fhlu_pkg::ST_MEM: begin
                    if (mem_ack_i) begin
                        state_r       <= fhlu_pkg::ST_IDLE;
                        instr_ready_o <= 1'b1;
                    end
                end
                default: begin
                    state_r       <= fhlu_pkg::ST_IDLE;
                    instr_ready_o <= 1'b1;
                end
            endcase
        end
    end

    // decoded fields and register read addresses held for the whole instruction
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dec_r         <= '0;
            base_raddr_o  <= 5'h00;
            index_raddr_o <= 5'h00;
        end else if (take && hit) begin
            dec_r         <= dec_nxt;
            base_raddr_o  <= dec_nxt.base;
            index_raddr_o <= dec_nxt.index;
        end
    end

    // storage request stands from the cycle after the address cycle until acknowledged
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_req_o  <= 1'b0;
            mem_addr_o <= 32'h0;
            mem_half_o <= 1'b0;
            ea_r       <= 32'h0;
        end else if (state_r == fhlu_pkg::ST_ADDR) begin
            mem_req_o  <= 1'b1;
            mem_addr_o <= ea_nxt;
            mem_half_o <= !dec_r.is_float;
            ea_r       <= ea_nxt;
        end else if (finish) begin
            mem_req_o  <= 1'b0;
        end
    end

    // writeback: one-cycle strobes; any exception means no register changes.
    // there is no port to status, exception or condition registers at all,
    // so both kinds of load leave them untouched
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_o      <= 1'b0;
            exc_align_o <= 1'b0;
            exc_dstor_o <= 1'b0;
            fpr_we_o    <= 1'b0;
            fpr_waddr_o <= 5'h00;
            fpr_wdata_o <= 64'h0;
            gpr_we_o    <= 1'b0;
            gpr_waddr_o <= 5'h00;
            gpr_wdata_o <= 32'h0;
            upd_we_o    <= 1'b0;
            upd_waddr_o <= 5'h00;
            upd_wdata_o <= 32'h0;
        end else begin
            done_o      <= finish;
            exc_align_o <= finish && mem_align_err_i;
            exc_dstor_o <= finish && mem_dstor_err_i;
            fpr_we_o    <= finish && !any_err && dec_r.is_float;
            gpr_we_o    <= finish && !any_err && !dec_r.is_float;
            upd_we_o    <= finish && !any_err && dec_r.update
                           && dec_r.base != fhlu_pkg::REG_ZERO
                           && (dec_r.is_float || dec_r.base != dec_r.tgt);
            if (finish) begin
                fpr_waddr_o <= dec_r.tgt;
                fpr_wdata_o <= widened;
                gpr_waddr_o <= dec_r.tgt;
                gpr_wdata_o <= {{16{mem_rdata_i[fhlu_pkg::HALF_SIGN]}}, mem_rdata_i[15:0]};
                upd_waddr_o <= dec_r.base;
                upd_wdata_o <= ea_r;
            end
        end
    end

    // checks and coverage
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_decode_half_upd: assert property (take && pri == fhlu_pkg::PRI_HALF_ALG_UPD
        |=> state_r == fhlu_pkg::ST_ADDR && dec_r.update && !dec_r.indexed && !dec_r.is_float)
        else $error("halfword update form misdecoded");
    a_decode_flt_upd: assert property (take && pri == fhlu_pkg::PRI_INDEXED
        && xo == fhlu_pkg::XO_FLT_UPD |=> dec_r.is_float && dec_r.update && dec_r.indexed)
        else $error("float update form misdecoded");
    a_ea_disp_form: assert property (state_r == fhlu_pkg::ST_ADDR && !dec_r.indexed
        |=> mem_addr_o == (($past(dec_r.base) == 5'h00) ? 32'h0 : $past(base_rdata_i))
                          + {{16{$past(dec_r.disp[15])}}, $past(dec_r.disp)})
        else $error("displacement address wrong");
    a_ea_index_form: assert property (state_r == fhlu_pkg::ST_ADDR && dec_r.indexed
        |=> mem_addr_o == (($past(dec_r.base) == 5'h00) ? 32'h0 : $past(base_rdata_i))
                          + $past(index_rdata_i))
        else $error("indexed address wrong");
    a_req_holds: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
        else $error("storage request dropped early");
    a_err_no_write: assert property (finish && any_err |=> !fpr_we_o && !gpr_we_o && !upd_we_o
        && done_o)
        else $error("write despite exception");
    a_upd_base_rule: assert property (upd_we_o |-> upd_waddr_o != 5'h00
        && (fpr_we_o || upd_waddr_o != gpr_waddr_o) && upd_wdata_o == $past(mem_addr_o))
        else $error("bad base update");
    a_half_sext: assert property (gpr_we_o |-> gpr_wdata_o ==
        {{16{$past(mem_rdata_i[15])}}, $past(mem_rdata_i[15:0])})
        else $error("halfword not sign extended");
    a_flt_sign: assert property (fpr_we_o |-> fpr_wdata_o[63] == $past(mem_rdata_i[31])
        && fpr_wdata_o[28:0] == 29'h0)
        else $error("float widening wrong");
    a_three_cycle: assert property (take && hit |=> !instr_ready_o [*2])
        else $error("accepted while busy");

    c_flt_upd: cover property (upd_we_o && fpr_we_o);
    c_half_upd: cover property (upd_we_o && gpr_we_o);
    c_align_err: cover property (exc_align_o);
    c_illegal: cover property (illegal_o);
endmodule
`default_nettype wire

// ---- fhlu_far_model.sv ----
// far-side model: register file read ports and a storage port with settable wait
`timescale 1ns/10ps
`default_nettype none
module fhlu_far_model (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // scenario controls from the bench
    input  wire logic [26:0] key_i,
    input  wire logic [1:0]  lat_i,
    input  wire logic [31:0] data_i,
    input  wire logic        align_i,
    input  wire logic        dstor_i,
    // register file read side
    input  wire logic [4:0]  base_raddr_i,
    input  wire logic [4:0]  index_raddr_i,
    output logic      [31:0] base_rdata_o,
    output logic      [31:0] index_rdata_o,
    // storage side
    input  wire logic        mem_req_i,
    output logic             mem_ack_o,
    output logic      [31:0] mem_rdata_o,
    output logic             mem_align_err_o,
    output logic             mem_dstor_err_o
);
    logic [1:0] cnt_r;

    // each register shows its own number on top, so a wrong read address is visible
    assign base_rdata_o  = {base_raddr_i, key_i};
    assign index_rdata_o = {index_raddr_i, key_i};

    // answer when the wait has run out; outside the answer data and flags are inverted
    assign mem_ack_o       = mem_req_i && (cnt_r == lat_i);
    assign mem_rdata_o     = mem_ack_o ? data_i : ~data_i;
    assign mem_align_err_o = mem_ack_o ? align_i : ~align_i;
    assign mem_dstor_err_o = mem_ack_o ? dstor_i : ~dstor_i;

    // wait counter, cleared by each answer so the next request starts fresh
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= 2'h0;
        end else if (mem_ack_o) begin
            cnt_r <= 2'h0;
        end else if (mem_req_i) begin
            cnt_r <= cnt_r + 2'h1;
        end
    end
endmodule
`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the float-single and halfword load unit
`timescale 1ns/10ps
`default_nettype none
module tb;
    typedef struct {
        logic        illegal, align, dstor, fwe, gwe, uwe, half;
        logic [4:0]  tgt, base;
        logic [31:0] ea, gdat;
        logic [63:0] fdat;
    } fhlu_exp_s;

    logic        clk, rst_n, valid, ready, illegal, done, mreq, mhalf, mack;
    logic        aerr, derr, xa, xd, fwe, gwe, uwe, align, dstor;
    logic [4:0]  braddr, iraddr, fwa, gwa, uwa;
    logic [31:0] instr, bdat, idat, maddr, mdat, gdat, udat, data;
    logic [63:0] fdat;
    logic [26:0] key;
    logic [1:0]  lat;
    int          fails, compares, cycles, seed;
    fhlu_exp_s   q[$];

    fhlu_load_unit dut_u (
        .clk_i(clk), .rst_n_i(rst_n), .instr_valid_i(valid), .instr_i(instr),
        .instr_ready_o(ready), .illegal_o(illegal), .done_o(done),
        .base_raddr_o(braddr), .index_raddr_o(iraddr), .base_rdata_i(bdat),
        .index_rdata_i(idat), .mem_req_o(mreq), .mem_addr_o(maddr), .mem_half_o(mhalf),
        .mem_ack_i(mack), .mem_rdata_i(mdat), .mem_align_err_i(aerr),
        .mem_dstor_err_i(derr), .exc_align_o(xa), .exc_dstor_o(xd),
        .fpr_we_o(fwe), .fpr_waddr_o(fwa), .fpr_wdata_o(fdat), .gpr_we_o(gwe),
        .gpr_waddr_o(gwa), .gpr_wdata_o(gdat), .upd_we_o(uwe), .upd_waddr_o(uwa),
        .upd_wdata_o(udat)
    );

    fhlu_far_model far_u (
        .clk_i(clk), .rst_n_i(rst_n), .key_i(key), .lat_i(lat), .data_i(data),
        .align_i(align), .dstor_i(dstor), .base_raddr_i(braddr), .index_raddr_i(iraddr),
        .base_rdata_o(bdat), .index_rdata_o(idat), .mem_req_i(mreq), .mem_ack_o(mack),
        .mem_rdata_o(mdat), .mem_align_err_o(aerr), .mem_dstor_err_o(derr)
    );

    // 20 MHz clock
    initial clk = 1'b0;
    always #25 clk = ~clk;

    task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // widening reference built from the two formats, class by class
    function automatic logic [63:0] widen(input logic [31:0] s);
        logic [63:0] d;
        int          p;
        p = -1;
        for (int k = 0; k < 23; k++) begin
            if (s[k]) begin
                p = k;
            end
        end
        if (s[30:23] == 8'hff) begin
            d = {s[31], fhlu_pkg::EXP_ALL_ONE, s[22:0], 29'h0};
        end else if (s[30:23] != 8'h00) begin
            d = {s[31], {3'h0, s[30:23]} + fhlu_pkg::EXP_REBIAS, s[22:0], 29'h0};
        end else if (p < 0) begin
            d = {s[31], 63'h0};
        end else begin
            // leading one moves out of the 52-bit field, the rest is the mantissa
            d = {s[31], fhlu_pkg::EXP_DENORM + 11'(p), {s[22:0], 29'h0} << (23 - p)};
        end
        return d;
    endfunction

    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // offer one instruction, hold it until taken, then wait for its end under a bound
    task automatic run(input logic [31:0] ins);
        int n;
        valid <= 1'b1;
        instr <= ins;
        do @(posedge clk); while (!ready);
        valid <= 1'b0;
        n = 0;
        while (!(done || illegal) && n < 40) begin
            @(posedge clk);
            n++;
        end
    endtask

    // hang guard: 60 loads of at most a dozen cycles fit well inside this
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            report_and_stop();
        end
    end

    // monitor: sampled mid-cycle so registered outputs have settled
    always @(negedge clk) begin
        fhlu_exp_s e;
        if (rst_n && mreq && mack) begin
            if (q.size() == 0) begin
                chk(72'h1, 72'h0);
            end else begin
                chk(maddr, q[0].ea);
                chk(mhalf, q[0].half);
            end
        end
        if (rst_n && (done || illegal)) begin
            if (q.size() == 0) begin
                chk(72'h1, 72'h0);
            end else begin
                e = q.pop_front();
                chk(illegal, e.illegal);
                chk({xa, xd}, {e.align, e.dstor});
                chk({fwe, gwe}, {e.fwe, e.gwe});
                chk(uwe, e.uwe);
                if (e.fwe) chk({fwa, fdat}, {e.tgt, e.fdat});
                if (e.gwe) chk({gwa, gdat}, {e.tgt, e.gdat});
                if (e.uwe) chk({uwa, udat}, {e.base, e.ea});
            end
        end
    end

    // stimulus: random mix of the five loads and two foreign opcodes
    initial begin
        fhlu_exp_s   e;
        logic [31:0] r1, r2, r3, ins;
        logic [4:0]  t, a, b;
        logic [5:0]  pri;
        logic [9:0]  xo;
        logic [2:0]  op;
        logic        idx, upd, flt, ill, al, ds;
        seed = 20;
        rst_n = 1'b0;
        valid = 1'b0;
        instr = 32'h0;
        {key, lat, data, align, dstor} = '0;
        fails = 0;
        compares = 0;
        cycles = 0;
        repeat (8) @(posedge clk);
        chk(ready, 1'b1);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 60; i++) begin
            r1 = $random(seed);
            r2 = $random(seed);
            r3 = $random(seed);
            op = 3'($unsigned(r2) % 7);
            // three passes in eight are forced to floats, so the odd input classes are reached
            if (i % 8 == 2 || i % 8 == 4 || i % 8 == 6) op = {2'h0, r2[0]};
            t = r1[4:0];
            a = (i % 4 == 0) ? 5'h00 : r1[9:5];
            b = r1[14:10];
            if (i % 5 == 1) t = a;
            al = (i % 7 == 3);
            ds = (i % 7 == 5);
            case (op)
                3'h0: {pri, xo} = {fhlu_pkg::PRI_INDEXED, fhlu_pkg::XO_FLT_UPD};
                3'h1: {pri, xo} = {fhlu_pkg::PRI_INDEXED, fhlu_pkg::XO_FLT};
                3'h2: {pri, xo} = {fhlu_pkg::PRI_HALF_ALG, 10'h000};
                3'h3: {pri, xo} = {fhlu_pkg::PRI_HALF_ALG_UPD, 10'h000};
                3'h4: {pri, xo} = {fhlu_pkg::PRI_INDEXED, fhlu_pkg::XO_HALF_UPD};
                3'h5: {pri, xo} = {6'h30, 10'h000};
                default: {pri, xo} = {fhlu_pkg::PRI_INDEXED, 10'h157};
            endcase
            idx = (op == 3'h0) || (op == 3'h1) || (op == 3'h4);
            upd = (op == 3'h0) || (op == 3'h3) || (op == 3'h4);
            flt = (op < 3'h2);
            ill = (op > 3'h4);
            // denormal, infinite or nan, and zero inputs besides random normals
            if (i % 8 == 2) r3[30:23] = 8'h00;
            if (i % 8 == 4) r3[30:23] = 8'hff;
            if (i % 8 == 6) r3[30:0] = 31'h0;
            // foreign indexed codes keep their extended field, so they stay foreign
            ins = {pri, t, a, (pri == fhlu_pkg::PRI_INDEXED) ? {b, xo, r2[10]} : r1[30:15]};
            e = '{default: '0};
            e.illegal = ill;
            e.half = !flt;
            e.tgt = t;
            e.base = a;
            e.ea = ((a == 5'h00) ? 32'h0 : {a, r2[31:5]})
                 + (idx ? {b, r2[31:5]} : {{16{r1[30]}}, r1[30:15]});
            e.align = !ill && al;
            e.dstor = !ill && ds;
            e.fwe = !ill && flt && !(al || ds);
            e.gwe = !ill && !flt && !(al || ds);
            e.uwe = !ill && upd && a != 5'h00 && (flt || a != t) && !(al || ds);
            e.fdat = widen(r3);
            e.gdat = {{16{r3[15]}}, r3[15:0]};
            q.push_back(e);
            key <= r2[31:5];
            lat <= r2[9:8];
            data <= r3;
            align <= al;
            dstor <= ds;
            run(ins);
        end
        repeat (4) @(posedge clk);
        chk(q.size() == 0, 1'b1);
        report_and_stop();
    end
endmodule
`default_nettype wire
